// *** verilog/mvr_regs.sv ***
// register interface of the meter: control, opcodes, status, id, reply, reading
`timescale 1ns/1ps

// How it works
// - control bit 0 holds device in reset
// - control bit 1 inhibits driving the fail line
// - fail line driven during and after failed self-test
// - control bit 2 triggers one measurement, only while waiting for trigger with control as sample source
// - command at 08, parameter at 0A, low bytes
// - checked error clears no-error flag, operation continues
// - id bits 15:14 report register-based class
// - id bits 13:12 report A16-only addressing
// - id bits 11:0 fixed manufacturer code
// - model register returns fixed model code
// - status bit 7 low while processing command
// - bit 6 no-error flag, low on error, code kept until read
// - bit 4 reading available, cleared on read/invalidate
// - bit 2 passed, bit 3 low means extended test
// - bit 1 query reply waiting, cleared on read
// - bit 0 ready for command, cleared on write
// - bit 7 valid only while bit 0 high
// - bits 6,5,4,1 valid only while bit 7 high
module mvr_regs
  import mvr_pkg::*;
#(
  parameter logic [11:0] MFR_CODE = 12'h5A3, // arbitrary value
  parameter logic [15:0] MODEL_CODE = 16'h1C2D, // arbitrary value
  parameter int P_CONV_CYC = mvr_pkg::CONV_CYC,
  parameter int P_AP2MS5_CYC = mvr_pkg::AP2MS5_CYC,
  parameter int P_AP16MS7_CYC = mvr_pkg::AP16MS7_CYC,
  parameter int P_AP20MS_CYC = mvr_pkg::AP20MS_CYC,
  parameter int P_AP267MS_CYC = mvr_pkg::AP267MS_CYC,
  parameter int P_AP320MS_CYC = mvr_pkg::AP320MS_CYC
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [mvr_pkg::ADDR_W-1:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [mvr_pkg::DATA_W-1:0] i_wdata,
  output logic [mvr_pkg::DATA_W-1:0] o_rdata,
  output logic o_dev_reset,
  output logic o_sysfail_oe_n,
  output logic o_sample,
  output logic o_cmd_strobe,
  output logic o_param_strobe,
  output logic [7:0] o_opcode,
  output logic o_reading_taken,
  input wire logic i_cmd_done,
  input wire logic i_cmd_error,
  input wire logic [7:0] i_error_code,
  input wire logic i_query_valid,
  input wire logic [7:0] i_query_data,
  input wire logic i_reading_valid,
  input wire logic [15:0] i_reading_data,
  input wire logic i_data_invalidate,
  input wire logic i_selftest_run,
  input wire logic i_selftest_ext,
  input wire logic i_selftest_fail,
  input wire logic i_wait_trigger,
  input wire logic i_sample_src_ctrl,
  input wire logic i_conv_start,
  input wire logic i_autozero,
  input wire logic [2:0] i_aperture
);
  import mvr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic ctrl_reset;
    logic fail_inhibit;
    mvr_cmd_st_e cmd_st;
    logic no_error;
    logic [7:0] err_code;
    logic err_pending;
    logic [7:0] q_data;
    logic q_ready;
    logic [15:0] reading;
    logic data_ready;
    logic [15:0] rdata;
    logic sysfail_oe_n;
    logic sample;
    logic cmd_strobe;
    logic param_strobe;
    logic [7:0] opcode;
    logic reading_taken;
  } mvr_regs_s;

  mvr_regs_s r_ff;
  mvr_regs_s nxt_r;
  logic conv_busy;
  logic conv_load;
  logic [TIMER_W-1:0] conv_len;
  logic [15:0] status_word;
  logic passed;

  ////////////////////////////////////////////////////////////////////////////////
  // conversion timer

  // autozero sets the flag length to the aperture, except the two longest
  always_comb
  begin
    conv_len = TIMER_W'(P_CONV_CYC);
    if (i_autozero)
    begin
      unique case (i_aperture)
        APER_16MS7: conv_len = TIMER_W'(P_AP16MS7_CYC);
        APER_20MS: conv_len = TIMER_W'(P_AP20MS_CYC);
        APER_2MS5: conv_len = TIMER_W'(P_AP2MS5_CYC);
        APER_100US: conv_len = TIMER_W'(AP100US_CYC);
        APER_10US: conv_len = TIMER_W'(AP10US_CYC);
        default: conv_len = TIMER_W'(P_CONV_CYC);
      endcase
    end
  end

  assign conv_load = (r_ff.sample | i_conv_start) & ~r_ff.ctrl_reset;

  mvr_timer #(
    .WIDTH(TIMER_W)
  ) u_conv_timer (
    .i_mclk(i_mclk),
    .i_reset(i_reset | r_ff.ctrl_reset),
    .i_load(conv_load),
    .i_count(conv_len),
    .o_busy(conv_busy)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // status word

  // an extended test keeps passed high, so bit 3 low with bit 2 high marks it
  assign passed = ~r_ff.ctrl_reset & ~i_selftest_fail & ~(i_selftest_run & ~i_selftest_ext);

  always_comb
  begin
    status_word = {UPPER_FILL, 8'h00};
    status_word[ST_READY] = (r_ff.cmd_st == CS_READY);
    status_word[ST_DONE] = (r_ff.cmd_st == CS_READY);
    status_word[ST_QUERY] = r_ff.q_ready;
    status_word[ST_PASSED] = passed;
    status_word[ST_EXTENDED] = ~(i_selftest_run & i_selftest_ext);
    status_word[ST_DATA] = r_ff.data_ready;
    status_word[ST_CONV] = conv_busy;
    status_word[ST_NO_ERROR_FLAG] = r_ff.no_error;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    nxt_r = r_ff;
    nxt_r.sample = 1'b0;
    nxt_r.cmd_strobe = 1'b0;
    nxt_r.param_strobe = 1'b0;
    nxt_r.reading_taken = 1'b0;

    // writes: only the low byte is looked at
    if (i_wr)
    begin
      unique case (i_addr)
        OFS_CTRL_STAT:
        begin
          nxt_r.ctrl_reset = i_wdata[CTL_RESET];
          nxt_r.fail_inhibit = i_wdata[CTL_FAIL_INHIBIT];
          nxt_r.sample = i_wdata[CTL_SAMPLE] & i_wait_trigger & i_sample_src_ctrl
            & ~r_ff.ctrl_reset;
        end
        OFS_CMD_QUERY:
        begin
          if (r_ff.cmd_st == CS_READY)
          begin
            nxt_r.opcode = i_wdata[7:0];
            nxt_r.cmd_strobe = 1'b1;
            nxt_r.cmd_st = CS_BUSY;
            nxt_r.no_error = 1'b1;
          end
        end
        OFS_PARAM:
        begin
          if (r_ff.cmd_st == CS_READY)
          begin
            nxt_r.opcode = i_wdata[7:0];
            nxt_r.param_strobe = 1'b1;
            nxt_r.cmd_st = CS_BUSY;
          end
        end
        default:
        begin
        end
      endcase
    end

    // reads: data is registered, side effects act with the read
    if (i_rd)
    begin
      unique case (i_addr)
        OFS_IDENT: nxt_r.rdata = {CLASS_REGISTER, ADDR_MODE_A16, MFR_CODE};
        OFS_MODEL: nxt_r.rdata = MODEL_CODE;
        OFS_CTRL_STAT: nxt_r.rdata = status_word;
        OFS_CMD_QUERY:
        begin
          if (r_ff.q_ready)
          begin
            nxt_r.rdata = {UPPER_FILL, r_ff.q_data};
            nxt_r.q_ready = 1'b0;
          end
          else
          begin
            nxt_r.rdata = {UPPER_FILL, r_ff.err_code};
            nxt_r.err_pending = 1'b0;
          end
        end
        OFS_READING:
        begin
          nxt_r.rdata = r_ff.reading;
          if (r_ff.data_ready)
          begin
            nxt_r.data_ready = 1'b0;
            nxt_r.reading_taken = 1'b1;
          end
        end
        default: nxt_r.rdata = RDATA_RST;
      endcase
    end

    // device side events: sets win over host clears
    if (i_data_invalidate)
      nxt_r.data_ready = 1'b0;
    if (i_reading_valid)
    begin
      nxt_r.reading = i_reading_data;
      nxt_r.data_ready = 1'b1;
    end
    if (i_query_valid)
    begin
      nxt_r.q_data = i_query_data;
      nxt_r.q_ready = 1'b1;
    end
    if (i_cmd_error)
    begin
      nxt_r.no_error = 1'b0;
      nxt_r.err_code = i_error_code;
      nxt_r.err_pending = 1'b1;
    end
    if (i_cmd_done && r_ff.cmd_st == CS_BUSY)
      nxt_r.cmd_st = CS_READY;

    // soft reset holds the handshake idle for as long as it is set
    unique case (r_ff.cmd_st)
      CS_RESET:
      begin
        if (!nxt_r.ctrl_reset)
          nxt_r.cmd_st = CS_READY;
      end
      CS_READY, CS_BUSY:
      begin
        if (nxt_r.ctrl_reset)
          nxt_r.cmd_st = CS_RESET;
      end
      default: nxt_r.cmd_st = CS_RESET;
    endcase
    if (r_ff.ctrl_reset)
    begin
      nxt_r.no_error = 1'b1;
      nxt_r.err_pending = 1'b0;
      nxt_r.q_ready = 1'b0;
      nxt_r.data_ready = 1'b0;
    end

    // open-drain fail line, enable low while pulling
    nxt_r.sysfail_oe_n = ~((i_selftest_run | i_selftest_fail)
      & ~nxt_r.fail_inhibit);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      r_ff <= '0;
      r_ff.cmd_st <= CS_READY;
      r_ff.no_error <= 1'b1;
      r_ff.sysfail_oe_n <= 1'b1;
      r_ff.rdata <= RDATA_RST;
      r_ff.reading <= WORD_RST;
      r_ff.q_data <= BYTE_RST;
      r_ff.err_code <= BYTE_RST;
      r_ff.opcode <= BYTE_RST;
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  assign o_rdata = r_ff.rdata;
  assign o_dev_reset = r_ff.ctrl_reset;
  assign o_sysfail_oe_n = r_ff.sysfail_oe_n;
  assign o_sample = r_ff.sample;
  assign o_cmd_strobe = r_ff.cmd_strobe;
  assign o_param_strobe = r_ff.param_strobe;
  assign o_opcode = r_ff.opcode;
  assign o_reading_taken = r_ff.reading_taken;
endmodule // mvr_regs

// *** verilog/mvr_pkg.sv ***
// constants and types shared by the meter register interface
package mvr_pkg;

  // register byte offsets within the 64-byte block
  localparam logic [5:0] OFS_IDENT = 6'h00;
  localparam logic [5:0] OFS_MODEL = 6'h02;
  localparam logic [5:0] OFS_CTRL_STAT = 6'h04;
  localparam logic [5:0] OFS_CMD_QUERY = 6'h08;
  localparam logic [5:0] OFS_PARAM = 6'h0A;
  localparam logic [5:0] OFS_READING = 6'h0C;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;

  // control bit positions
  localparam int CTL_RESET = 0;
  localparam int CTL_FAIL_INHIBIT = 1;
  localparam int CTL_SAMPLE = 2;

  // status bit positions
  localparam int ST_READY = 0;
  localparam int ST_QUERY = 1;
  localparam int ST_PASSED = 2;
  localparam int ST_EXTENDED = 3;
  localparam int ST_DATA = 4;
  localparam int ST_CONV = 5;
  localparam int ST_NO_ERROR_FLAG = 6;
  localparam int ST_DONE = 7;

  // identification fields
  localparam logic [1:0] CLASS_REGISTER = 2'h3;
  localparam logic [1:0] ADDR_MODE_A16 = 2'h3;
  localparam logic [7:0] UPPER_FILL = 8'hFF;

  // values after reset
  localparam logic [15:0] RDATA_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;

  // aperture opcodes
  localparam logic [2:0] APER_267MS = 3'h0;
  localparam logic [2:0] APER_16MS7 = 3'h1;
  localparam logic [2:0] APER_320MS = 3'h2;
  localparam logic [2:0] APER_20MS = 3'h3;
  localparam logic [2:0] APER_2MS5 = 3'h4;
  localparam logic [2:0] APER_100US = 3'h5;
  localparam logic [2:0] APER_10US = 3'h6;

  // times in microseconds, cycle counts at the 20 MHz clock
  localparam int CLK_MHZ = 20;
  localparam int CONV_US = 400;
  localparam int AP10US_US = 10;
  localparam int AP100US_US = 100;
  localparam int AP2MS5_US = 2500;
  localparam int AP16MS7_US = 16700;
  localparam int AP20MS_US = 20000;
  localparam int AP267MS_US = 267000;
  localparam int AP320MS_US = 320000;
  localparam int CONV_CYC = CONV_US * CLK_MHZ;
  localparam int AP10US_CYC = AP10US_US * CLK_MHZ;
  localparam int AP100US_CYC = AP100US_US * CLK_MHZ;
  localparam int AP2MS5_CYC = AP2MS5_US * CLK_MHZ;
  localparam int AP16MS7_CYC = AP16MS7_US * CLK_MHZ;
  localparam int AP20MS_CYC = AP20MS_US * CLK_MHZ;
  localparam int AP267MS_CYC = AP267MS_US * CLK_MHZ;
  localparam int AP320MS_CYC = AP320MS_US * CLK_MHZ;
  localparam int TIMER_W = 24;

  // command handshake states
  typedef enum logic [2:0] {
    CS_RESET = 3'b001,
    CS_READY = 3'b010,
    CS_BUSY = 3'b100
  } mvr_cmd_st_e;

endpackage : mvr_pkg

// *** verilog/mvr_timer.sv ***
// loadable countdown that holds a busy level until it expires
`timescale 1ns/1ps
module mvr_timer #(
  parameter int WIDTH = 24
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_count,
  output logic o_busy
);
  import mvr_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic busy;
  } mvr_timer_s;

  mvr_timer_s r_ff;
  mvr_timer_s nxt_r;

  always_comb
  begin
    nxt_r = r_ff;
    if (i_load)
    begin
      nxt_r.count = i_count;
      nxt_r.busy = 1'b1;
    end
    else if (r_ff.busy)
    begin
      nxt_r.count = r_ff.count - 1'b1;
      if (r_ff.count <= 1)
        nxt_r.busy = 1'b0;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
      r_ff <= '0;
    else
      r_ff <= nxt_r;
  end

  assign o_busy = r_ff.busy;
endmodule // mvr_timer

// *** bench/mvr_regs_properties.sv ***
// port checker of the meter register interface
`timescale 1ns/1ps
module mvr_regs_properties #(
  parameter logic [11:0] MFR_CODE = 12'h5A3,
  parameter logic [15:0] MODEL_CODE = 16'h1C2D
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [mvr_pkg::ADDR_W-1:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [mvr_pkg::DATA_W-1:0] i_wdata,
  input wire logic [mvr_pkg::DATA_W-1:0] o_rdata,
  input wire logic o_dev_reset,
  input wire logic o_sysfail_oe_n,
  input wire logic o_sample,
  input wire logic o_cmd_strobe,
  input wire logic o_param_strobe,
  input wire logic [7:0] o_opcode,
  input wire logic o_reading_taken,
  input wire logic i_selftest_fail,
  input wire logic i_wait_trigger,
  input wire logic i_sample_src_ctrl
);
  import mvr_pkg::*;
  wire logic w4 = i_wr && i_addr == OFS_CTRL_STAT;
  wire logic r4 = i_rd && i_addr == OFS_CTRL_STAT;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  AST_SOFT_RESET: assert property (w4 |=> o_dev_reset == $past(i_wdata[0]))
    else $error("soft reset level wrong");
  AST_INHIBIT: assert property (w4 && i_wdata[1] |=> o_sysfail_oe_n)
    else $error("fail line driven while inhibited");
  AST_FAIL_DRIVE: assert property (w4 && !i_wdata[1] && i_selftest_fail
    |=> !o_sysfail_oe_n) else $error("fail line not driven");
  AST_SAMPLE: assert property (w4 && i_wdata[2] && !i_wdata[0] && !o_dev_reset
    && i_wait_trigger && i_sample_src_ctrl |=> o_sample ##1 !o_sample)
    else $error("sample not single");
  AST_SAMPLE_CAUSE: assert property (o_sample |-> $past(w4 && i_wdata[2]))
    else $error("sample without write");
  AST_OPCODE: assert property (o_cmd_strobe || o_param_strobe
    |-> o_opcode == $past(i_wdata[7:0])) else $error("opcode byte wrong");
  AST_CMD_CAUSE: assert property (o_cmd_strobe |-> $past(i_wr && i_addr == OFS_CMD_QUERY))
    else $error("command strobe without write");
  AST_IDENT: assert property (i_rd && i_addr == OFS_IDENT |=> o_rdata == {4'hF, MFR_CODE})
    else $error("identification wrong");
  AST_MODEL: assert property (i_rd && i_addr == OFS_MODEL |=> o_rdata == MODEL_CODE)
    else $error("model code wrong");
  AST_STATUS: assert property (r4 |=> o_rdata[15:8] == UPPER_FILL
    && o_rdata[7] == o_rdata[0]) else $error("status frame wrong");
  AST_PASSED: assert property (r4 && o_dev_reset |=> !o_rdata[2] && !o_rdata[0])
    else $error("passed during reset");
  AST_TAKEN: assert property (o_reading_taken |-> $past(i_rd && i_addr == OFS_READING))
    else $error("reading taken without read");
endmodule // mvr_regs_properties
bind mvr_regs mvr_regs_properties #(.MFR_CODE(MFR_CODE), .MODEL_CODE(MODEL_CODE)) u_props (
  .i_mclk, .i_reset, .i_addr, .i_wr, .i_rd, .i_wdata, .o_rdata, .o_dev_reset, .o_sysfail_oe_n,
  .o_sample, .o_cmd_strobe, .o_param_strobe, .o_opcode, .o_reading_taken, .i_selftest_fail,
  .i_wait_trigger, .i_sample_src_ctrl);

// *** bench/mvr_host.sv ***
// bus controller model for the meter registers
`timescale 1ns/1ps
module mvr_host (
  input wire logic i_mclk,
  input wire logic [mvr_pkg::DATA_W-1:0] i_rdata,
  output logic [mvr_pkg::ADDR_W-1:0] o_addr = 6'h00,
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0,
  output logic [mvr_pkg::DATA_W-1:0] o_wdata = 16'h0000
);
  import mvr_pkg::*;
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_mclk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge i_mclk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_mclk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    @(negedge i_mclk);
    d = i_rdata;
  endtask
  task automatic poll(input int b);
    logic [15:0] s;
    s = 16'h0000;
    for (int i = 0; i < 60 && !s[b]; i++) rd(OFS_CTRL_STAT, s);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] pr);
    poll(ST_READY);
    wr(OFS_CMD_QUERY, {8'hA5, op});
    poll(ST_READY);
    wr(OFS_PARAM, {8'h5A, pr});
    poll(ST_DONE);
  endtask
  task automatic reset_dev(output logic [15:0] s);
    wr(OFS_CTRL_STAT, 16'h0002);
    wr(OFS_CTRL_STAT, 16'h0003);
    rd(OFS_CTRL_STAT, s);
    repeat (40) @(posedge i_mclk);
    wr(OFS_CTRL_STAT, 16'h0002);
    poll(ST_PASSED);
    wr(OFS_CTRL_STAT, 16'h0000);
  endtask
endmodule // mvr_host

// *** bench/tb.sv ***
// self-checking bench of the meter register interface
`timescale 1ns/1ps
module tb;
  import mvr_pkg::*;
  localparam logic [11:0] MFR = 12'h5A3; // arbitrary value
  localparam logic [15:0] MDL = 16'h1C2D; // arbitrary value
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic [5:0] i_addr;
  logic i_wr, i_rd;
  logic [15:0] i_wdata, o_rdata, i_reading_data = 16'h0000, s;
  logic o_dev_reset, o_sysfail_oe_n, o_sample, o_cmd_strobe, o_param_strobe, o_reading_taken;
  logic [7:0] o_opcode, op, i_error_code = 8'h00, i_query_data = 8'h00;
  logic i_cmd_done = 0, i_cmd_error = 0, i_query_valid = 0, i_reading_valid = 0;
  logic i_data_invalidate = 0, i_selftest_fail = 0, i_wait_trigger = 0, i_sample_src_ctrl = 0;
  logic i_selftest_run = 0, i_selftest_ext = 0, i_autozero = 0;
  logic [2:0] i_aperture = 3'h0;
  logic [31:0] seed = 32'h0be3, r;
  logic [5:0] ta[3] = '{OFS_IDENT, OFS_MODEL, 6'h06};
  logic [15:0] te[3] = '{{4'hF, MFR}, MDL, 16'h0000};
  logic [7:0] qq[$];
  logic [15:0] rq[$];
  int n_fail = 0, check_count = 0, cyc = 0, cnt = 0, ns = 0, n0, m_ne = 1, m_d = 0, m_q = 0;
  int nt = 0;
  mvr_host host (.i_mclk, .i_rdata(o_rdata), .o_addr(i_addr), .o_wr(i_wr), .o_rd(i_rd),
    .o_wdata(i_wdata));
  mvr_regs #(.MFR_CODE(MFR), .MODEL_CODE(MDL), .P_CONV_CYC(20), .P_AP2MS5_CYC(40)) DUT (
    .i_mclk, .i_reset,
    .i_addr, .i_wr, .i_rd, .i_wdata, .o_rdata, .o_dev_reset, .o_sysfail_oe_n, .o_sample,
    .o_cmd_strobe, .o_param_strobe, .o_opcode, .o_reading_taken, .i_cmd_done, .i_cmd_error,
    .i_error_code, .i_query_valid, .i_query_data, .i_reading_valid, .i_reading_data,
    .i_data_invalidate, .i_selftest_run, .i_selftest_ext, .i_selftest_fail,
    .i_wait_trigger, .i_sample_src_ctrl, .i_conv_start(1'b0), .i_autozero,
    .i_aperture);
  always #25 i_mclk = ~i_mclk;
  ////////////////////////////////////////////////////////////////////////////////
  // core stub: done four cycles after each strobe, opcode FF is refused
  always @(posedge i_mclk)
  begin
    i_cmd_done <= (cnt == 1);
    i_cmd_error <= (cnt == 1) && (o_opcode == 8'hFF);
    cnt <= (o_cmd_strobe || o_param_strobe) ? 3 : (cnt > 0 ? cnt - 1 : 0);
    ns <= ns + o_sample;
    nt <= nt + o_reading_taken;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      complete_run();
    end
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] st(input int cv);
    return {8'hFF, 1'b1, m_ne[0], cv[0], m_d[0], 1'b1, 1'b1, m_q[0], 1'b1};
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic core(input int k, input logic [15:0] d);
    @(posedge i_mclk);
    i_query_data <= d[7:0];
    i_reading_data <= d;
    i_query_valid <= (k == 0);
    i_reading_valid <= (k == 1);
    i_data_invalidate <= (k == 2);
    @(posedge i_mclk);
    i_query_valid <= 1'b0;
    i_reading_valid <= 1'b0;
    i_data_invalidate <= 1'b0;
    i_reading_data <= ~d;
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge i_mclk);
    i_reset <= 1'b0;
    host.rd(OFS_CTRL_STAT, s);
    chk(s, st(0));
    foreach (ta[i])
    begin
      host.wr(ta[i], 16'h0000);
      host.rd(ta[i], s);
      chk(s, te[i]);
    end
    @(posedge i_mclk) i_selftest_run <= 1'b1;
    host.rd(OFS_CTRL_STAT, s);
    chk(s, 16'hFFC9);
    chk({15'h0, o_sysfail_oe_n}, 16'h0000);
    @(posedge i_mclk) i_selftest_ext <= 1'b1;
    host.rd(OFS_CTRL_STAT, s);
    chk(s, 16'hFFC5);
    @(posedge i_mclk) i_selftest_run <= 1'b0;
    i_selftest_ext <= 1'b0;
    @(posedge i_mclk) i_selftest_fail <= 1'b1;
    host.wr(OFS_CTRL_STAT, 16'h0000);
    #1 chk({15'h0, o_sysfail_oe_n}, 16'h0000);
    host.wr(OFS_CTRL_STAT, 16'h0002);
    #1 chk({15'h0, o_sysfail_oe_n}, 16'h0001);
    @(posedge i_mclk) i_selftest_fail <= 1'b0;
    host.reset_dev(s);
    chk(s, 16'hFF48);
    for (int k = 0; k < 5; k++)
    begin
      r = xs();
      op = (k == 2) ? 8'hFF : {1'b0, r[6:0]};
      @(posedge i_mclk) i_error_code <= r[23:16];
      host.cmd(op, {1'b0, r[14:8]});
      m_ne = (op != 8'hFF);
      host.rd(OFS_CTRL_STAT, s);
      chk(s, st(0));
      host.rd(OFS_CMD_QUERY, s);
      if (k == 2) chk(s, {8'hFF, r[23:16]});
    end
    for (int k = 0; k < 2; k++)
    begin
      r = xs();
      core(0, r[15:0]);
      qq.push_back(r[7:0]);
      m_q = 1;
      host.rd(OFS_CTRL_STAT, s);
      chk(s, st(0));
      host.rd(OFS_CMD_QUERY, s);
      m_q = 0;
      chk(s, {8'hFF, qq.pop_front()});
      host.rd(OFS_CTRL_STAT, s);
      chk(s, st(0));
    end
    r = xs();
    core(1, r[15:0]);
    rq.push_back(r[15:0]);
    m_d = 1;
    host.rd(OFS_CTRL_STAT, s);
    chk(s, st(0));
    host.rd(OFS_READING, s);
    m_d = 0;
    chk(s, rq.pop_front());
    host.rd(OFS_CTRL_STAT, s);
    chk(s, st(0));
    chk(16'(nt), 16'h0001);
    core(1, r[31:16]);
    core(2, 16'h0000);
    host.rd(OFS_CTRL_STAT, s);
    chk(s, st(0));
    @(posedge i_mclk) i_wait_trigger <= 1'b1;
    i_sample_src_ctrl <= 1'b1;
    n0 = ns;
    host.wr(OFS_CTRL_STAT, 16'hA5FC);
    host.rd(OFS_CTRL_STAT, s);
    chk(s, st(1));
    repeat (30) @(posedge i_mclk);
    host.rd(OFS_CTRL_STAT, s);
    chk(s, st(0));
    chk(16'(ns - n0), 16'h0001);
    @(posedge i_mclk) i_autozero <= 1'b1;
    i_aperture <= APER_2MS5;
    host.wr(OFS_CTRL_STAT, 16'h0004);
    repeat (30) @(posedge i_mclk);
    host.rd(OFS_CTRL_STAT, s);
    chk(s, st(1));
    repeat (10) @(posedge i_mclk);
    host.rd(OFS_CTRL_STAT, s);
    chk(s, st(0));
    @(posedge i_mclk) i_reset <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_reset <= 1'b0;
    host.rd(OFS_CTRL_STAT, s);
    chk(s, st(0));
    chk({8'h00, o_opcode}, 16'h0000);
    complete_run();
  end
endmodule // tb
